// file: hdl/oag_core.v
// Operand effective-address generator with a Wishbone page select register
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "oag_defines.vh"

module oag_core #(
  parameter AW = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [AW-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire req_i,
  input wire [3:0] mode_i,
  input wire [7:0] opnd_lo_i,
  input wire [7:0] opnd_hi_i,
  input wire [7:0] x_i,
  input wire [7:0] y_i,
  input wire page_extend_i,
  input wire rmw_i,
  output reg busy_o,
  output reg done_o,
  output reg [1:0] kind_o,
  output reg [15:0] ea_o,
  output reg [7:0] imm_o,
  output reg rmw_o,
  output reg x_wr_o,
  output reg [7:0] x_next_o,
  output reg mem_req_o,
  output reg [15:0] mem_addr_o,
  input wire mem_ack_i,
  input wire [7:0] mem_rdata_i
);

  // ===========================================================================
  // State codes
  // ===========================================================================
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PTR_LO = 2'h1;
  localparam [1:0] ST_PTR_HI = 2'h2;

  reg [1:0] state_q; // Pointer fetch sequencer
  reg page_select_bit_q; // Only stored bit of the page register
  reg [7:0] y_q; // Y captured for the indirect plus Y form
  reg add_y_q; // Add Y once the pointer is known
  reg [7:0] ptr_lo_q; // Low pointer byte fetched
  reg [7:0] ptr_base_q; // In-page location of the pointer low byte
  reg [7:0] page_q; // Page used for the pointer fetch
  reg rmw_q; // Read-modify-write marker for the pending result

  // ===========================================================================
  // Combinational address forms
  // ===========================================================================
  wire [7:0] cur_page; // Page of the direct-page area
  wire [7:0] dp_plus_x; // Operand plus X inside the page
  wire [7:0] dp_plus_y; // Operand plus Y inside the page
  wire [15:0] abs_addr; // Full absolute operand
  wire [15:0] abs_plus_y; // Absolute operand plus Y
  wire [15:0] ptr_word; // Pointer formed from both fetched bytes
  wire wb_hit; // Valid bus cycle awaiting an answer
  wire [AW-3:0] wb_idx; // Word index on the bus

  // Page is the register bit only when extension is on
  assign cur_page = page_extend_i ? {7'h00, page_select_bit_q} : 8'h00;
  // Sums are cut to eight bits so they stay in the page
  assign dp_plus_x = opnd_lo_i + x_i;
  assign dp_plus_y = opnd_lo_i + y_i;
  // Second byte is low, third byte is high, no page involved
  assign abs_addr = {opnd_hi_i, opnd_lo_i};
  assign abs_plus_y = abs_addr + {8'h00, y_i};
  assign ptr_word = {mem_rdata_i, ptr_lo_q};
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_idx = wb_adr_i[AW-1:2];

  // ===========================================================================
  // Wishbone slave: page register and status
  // ===========================================================================
  // Answers every access one cycle after the strobe; unmapped reads give zero
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      page_select_bit_q <= `OAG_PAGE_RESET;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h00000000;
      if (wb_hit & wb_we_i & wb_sel_i[0] & (wb_idx == `OAG_IDX_PAGE))
      begin
        // Only bit zero is kept; the rest of the byte is dropped
        page_select_bit_q <= wb_dat_i[`OAG_PAGE_BIT];
      end
      if (wb_hit & ~wb_we_i)
      begin
        if (wb_idx == `OAG_IDX_PAGE)
        begin
          // Unused bits read as zero
          wb_dat_o[`OAG_PAGE_BIT] <= page_select_bit_q;
        end
        else if (wb_idx == `OAG_IDX_STATUS)
        begin
          // Last address formed and the busy flag
          wb_dat_o <= {15'h0000, busy_o, ea_o};
        end
        else
        begin
          // Unmapped index reads zero
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  // ===========================================================================
  // Address sequencer
  // ===========================================================================
  // Direct modes finish in one cycle; indirect modes fetch two pointer bytes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      kind_o <= `OAG_K_NONE;
      ea_o <= 16'h0000;
      imm_o <= 8'h00;
      rmw_o <= 1'b0;
      x_wr_o <= 1'b0;
      x_next_o <= 8'h00;
      mem_req_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      y_q <= 8'h00;
      add_y_q <= 1'b0;
      ptr_lo_q <= 8'h00;
      ptr_base_q <= 8'h00;
      page_q <= 8'h00;
      rmw_q <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      x_wr_o <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (req_i)
          begin
            rmw_o <= 1'b0;
            case (mode_i)
              `OAG_M_REG:
              begin
                // Operand lives in a core register, no address
                done_o <= 1'b1;
                kind_o <= `OAG_K_NONE;
              end
              `OAG_M_IMM:
              begin
                // Byte after the opcode is the value itself
                done_o <= 1'b1;
                kind_o <= `OAG_K_IMM;
                imm_o <= opnd_lo_i;
              end
              `OAG_M_DP:
              begin
                done_o <= 1'b1;
                kind_o <= `OAG_K_ADDR;
                ea_o <= {cur_page, opnd_lo_i};
                rmw_o <= rmw_i;
              end
              `OAG_M_ABS:
              begin
                done_o <= 1'b1;
                kind_o <= `OAG_K_ADDR;
                ea_o <= abs_addr;
                // Read and write back at the same address
                rmw_o <= rmw_i;
              end
              `OAG_M_XDP:
              begin
                done_o <= 1'b1;
                kind_o <= `OAG_K_ADDR;
                ea_o <= {cur_page, x_i};
              end
              `OAG_M_XINC:
              begin
                // Access at old X while X+1 is handed back
                done_o <= 1'b1;
                kind_o <= `OAG_K_ADDR;
                ea_o <= {cur_page, x_i};
                x_wr_o <= 1'b1;
                x_next_o <= x_i + 8'h01;
              end
              `OAG_M_DPX:
              begin
                done_o <= 1'b1;
                kind_o <= `OAG_K_ADDR;
                ea_o <= {cur_page, dp_plus_x};
                rmw_o <= rmw_i;
              end
              `OAG_M_DPY:
              begin
                done_o <= 1'b1;
                kind_o <= `OAG_K_ADDR;
                ea_o <= {cur_page, dp_plus_y};
              end
              `OAG_M_ABSY:
              begin
                done_o <= 1'b1;
                kind_o <= `OAG_K_ADDR;
                ea_o <= abs_plus_y;
              end
              `OAG_M_DPIND, `OAG_M_XIND, `OAG_M_YIND:
              begin
                // Start fetching the pointer low byte
                busy_o <= 1'b1;
                state_q <= ST_PTR_LO;
                mem_req_o <= 1'b1;
                page_q <= cur_page;
                y_q <= y_i;
                rmw_q <= rmw_i;
                add_y_q <= (mode_i == `OAG_M_YIND);
                if (mode_i == `OAG_M_XIND)
                begin
                  ptr_base_q <= dp_plus_x;
                  mem_addr_o <= {cur_page, dp_plus_x};
                end
                else
                begin
                  ptr_base_q <= opnd_lo_i;
                  mem_addr_o <= {cur_page, opnd_lo_i};
                end
              end
              default:
              begin
                // Unknown mode answers with no address
                done_o <= 1'b1;
                kind_o <= `OAG_K_NONE;
              end
            endcase
          end
        end
        ST_PTR_LO:
        begin
          if (mem_ack_i)
          begin
            // Low byte taken; drop the request for one cycle
            ptr_lo_q <= mem_rdata_i;
            mem_req_o <= 1'b0;
            mem_addr_o <= {page_q, ptr_base_q + 8'h01};
            state_q <= ST_PTR_HI;
          end
        end
        ST_PTR_HI:
        begin
          if (~mem_req_o)
          begin
            // Ask for the high byte at the next location
            mem_req_o <= 1'b1;
          end
          else if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            kind_o <= `OAG_K_ADDR;
            rmw_o <= rmw_q;
            state_q <= ST_IDLE;
            if (add_y_q)
            begin
              ea_o <= ptr_word + {8'h00, y_q};
            end
            else
            begin
              ea_o <= ptr_word;
            end
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          busy_o <= 1'b0;
          mem_req_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // oag_core
`default_nettype wire

// file: hdl/oag_defines.vh
// Constants for the operand address generator: register map, modes, result kinds
`ifndef OAG_DEFINES_VH
`define OAG_DEFINES_VH

// ===========================================================================
// Register indices (byte address is four times the index)
// ===========================================================================
`define OAG_IDX_PAGE 10'h0E1
`define OAG_IDX_STATUS 10'h0F8
`define OAG_PAGE_BIT 0
`define OAG_PAGE_RESET 1'b0
`define OAG_STAT_BUSY_BIT 16

// ===========================================================================
// Addressing modes on mode_i
// ===========================================================================
`define OAG_M_REG 4'h0
`define OAG_M_IMM 4'h1
`define OAG_M_DP 4'h2
`define OAG_M_ABS 4'h3
`define OAG_M_XDP 4'h4
`define OAG_M_XINC 4'h5
`define OAG_M_DPX 4'h6
`define OAG_M_DPY 4'h7
`define OAG_M_ABSY 4'h8
`define OAG_M_DPIND 4'h9
`define OAG_M_XIND 4'hA
`define OAG_M_YIND 4'hB

// ===========================================================================
// Result kinds on kind_o
// ===========================================================================
`define OAG_K_NONE 2'h0
`define OAG_K_IMM 2'h1
`define OAG_K_ADDR 2'h2

`endif

// file: verif/oag_core_asserts.sv
// Port assertions for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module oag_core_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire req_i,
  input wire [3:0] mode_i,
  input wire [7:0] opnd_lo_i,
  input wire [7:0] opnd_hi_i,
  input wire [7:0] x_i,
  input wire [7:0] y_i,
  input wire busy_o,
  input wire done_o,
  input wire [1:0] kind_o,
  input wire [15:0] ea_o,
  input wire [7:0] imm_o,
  input wire x_wr_o,
  input wire [7:0] x_next_o,
  input wire mem_req_o
);
  // ==========
  // One clock domain, reset disables all checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire go = req_i && !busy_o; // Request taken this edge
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack missing");
  property p_reg; go && mode_i == 4'h0 |=> done_o && kind_o == 2'h0; endproperty
  a_reg: assert property (p_reg) else $error("register mode kind");
  property p_imm; go && mode_i == 4'h1 |=> kind_o == 2'h1 && imm_o == $past(opnd_lo_i); endproperty
  a_imm: assert property (p_imm) else $error("immediate value");
  property p_dp; go && mode_i == 4'h2 |=> ea_o[7:0] == $past(opnd_lo_i) && ea_o[15:9] == 7'h00; endproperty
  a_dp: assert property (p_dp) else $error("direct page address");
  property p_abs; go && mode_i == 4'h3 |=> ea_o == {$past(opnd_hi_i), $past(opnd_lo_i)}; endproperty
  a_abs: assert property (p_abs) else $error("absolute address");
  property p_xdp; go && mode_i == 4'h4 |=> done_o && ea_o[7:0] == $past(x_i); endproperty
  a_xdp: assert property (p_xdp) else $error("x page address");
  property p_xinc; go && mode_i == 4'h5 |=> x_wr_o && x_next_o == $past(x_i) + 8'h01; endproperty
  a_xinc: assert property (p_xinc) else $error("x increment");
  property p_dpx; go && mode_i == 4'h6 |=> ea_o[7:0] == $past(opnd_lo_i) + $past(x_i); endproperty
  a_dpx: assert property (p_dpx) else $error("x offset address");
  property p_dpy; go && mode_i == 4'h7 |=> ea_o[7:0] == $past(opnd_lo_i) + $past(y_i); endproperty
  a_dpy: assert property (p_dpy) else $error("y offset address");
  property p_absy; go && mode_i == 4'h8 |=> ea_o == {$past(opnd_hi_i), $past(opnd_lo_i)} + $past(y_i); endproperty
  a_absy: assert property (p_absy) else $error("absolute y address");
  property p_ind; go && mode_i >= 4'h9 && mode_i <= 4'hB |=> busy_o && mem_req_o && !done_o; endproperty
  a_ind: assert property (p_ind) else $error("pointer fetch start");
  // Main scenarios reached
  c_xinc: cover property (go && mode_i == 4'h5);
  c_yind: cover property (go && mode_i == 4'hB);
  c_bus: cover property (wb_ack_o);
endmodule // oag_core_asserts
bind oag_core oag_core_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .req_i(req_i), .mode_i(mode_i),
  .opnd_lo_i(opnd_lo_i), .opnd_hi_i(opnd_hi_i), .x_i(x_i), .y_i(y_i), .busy_o(busy_o),
  .done_o(done_o), .kind_o(kind_o), .ea_o(ea_o), .imm_o(imm_o), .x_wr_o(x_wr_o),
  .x_next_o(x_next_o), .mem_req_o(mem_req_o));
`default_nettype wire

// file: verif/tb_oag_core.sv
// Random and corner tests for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module tb_oag_core;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0, mode_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic req_i = 1'b0, page_extend_i = 1'b0, rmw_i = 1'b0, mem_ack_i = 1'b0, pg = 1'b0;
  logic [7:0] opnd_lo_i = 8'h00, opnd_hi_i = 8'h00, x_i = 8'h00, y_i = 8'h00, mem_rdata_i = 8'h00;
  logic wb_ack_o, busy_o, done_o, rmw_o, x_wr_o, mem_req_o;
  logic [1:0] kind_o;
  logic [15:0] ea_o, mem_addr_o;
  logic [7:0] imm_o, x_next_o;
  int fail_count = 0, check_count = 0;
  oag_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i), .mode_i(mode_i),
    .opnd_lo_i(opnd_lo_i), .opnd_hi_i(opnd_hi_i), .x_i(x_i), .y_i(y_i),
    .page_extend_i(page_extend_i), .rmw_i(rmw_i), .busy_o(busy_o), .done_o(done_o),
    .kind_o(kind_o), .ea_o(ea_o), .imm_o(imm_o), .rmw_o(rmw_o), .x_wr_o(x_wr_o),
    .x_next_o(x_next_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
  // ==========
  // Clock, memory responder and models
  always #2 clk_i = ~clk_i;
  // Pointer byte contents depend on the whole address
  function automatic logic [7:0] mem_f(input logic [15:0] a);
    return (a[7:0] * 8'h07) ^ a[15:8];
  endfunction
  // One-cycle ack after a random stall
  always @(posedge clk_i)
  begin
    mem_ack_i <= mem_req_o && !mem_ack_i && $urandom_range(1);
    mem_rdata_i <= mem_f(mem_addr_o);
  end
  // Expected effective address
  function automatic logic [15:0] exp_ea(input logic [3:0] m, input logic [7:0] lo, hi, x, y,
    input logic g);
    logic [7:0] p, b;
    p = {7'h00, g & pg};
    b = (m == 4'hA) ? lo + x : lo;
    case (m)
      4'h2: return {p, lo};
      4'h3: return {hi, lo};
      4'h4, 4'h5: return {p, x};
      4'h6: return {p, lo + x};
      4'h7: return {p, lo + y};
      4'h8: return {hi, lo} + y;
      4'hB: return {mem_f({p, b + 8'h01}), mem_f({p, b})} + y;
      default: return {mem_f({p, b + 8'h01}), mem_f({p, b})};
    endcase
  endfunction
  task automatic close_out;
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // A used-up wait ends the run
  task automatic bound(input int n);
    if (n >= 40)
    begin
      fail_count++;
      close_out();
    end
  endtask
  // ==========
  // Bus and request drivers
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    // Ack is looked at on rising edges only; read data is taken at that same edge
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    bound(n);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic op(input logic [3:0] m, input logic [7:0] lo, hi, x, y, input logic g, rw);
    int n;
    logic [1:0] k;
    k = (m == 4'h1) ? 2'h1 : ((m == 4'h0 || m > 4'hB) ? 2'h0 : 2'h2);
    @(posedge clk_i);
    req_i <= 1'b1;
    mode_i <= m;
    opnd_lo_i <= lo;
    opnd_hi_i <= hi;
    x_i <= x;
    y_i <= y;
    page_extend_i <= g;
    rmw_i <= rw;
    @(posedge clk_i);
    req_i <= 1'b0;
    n = 0;
    // Result is taken at the rising edge that sees the done pulse
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (done_o !== 1'b1 && n < 40);
    bound(n);
    chk(kind_o, k);
    if (k == 2'h2) chk(ea_o, exp_ea(m, lo, hi, x, y, g));
    if (m == 4'h1) chk(imm_o, lo);
    if (m == 4'h5) chk({x_wr_o, x_next_o}, {1'b1, x + 8'h01});
    if (m == 4'h3) chk(rmw_o, rw);
  endtask
  // ==========
  // Main sequence
  initial
  begin
    logic [31:0] r;
    void'($urandom(67712));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 12'h384, 32'h0, 4'h1, r);
    chk(r, 32'h0);
    wb(1'b1, 12'h384, 32'hFFFFFFFF, 4'hF, r);
    wb(1'b1, 12'h384, 32'h0, 4'hE, r);
    wb(1'b0, 12'h384, 32'h0, 4'hF, r);
    chk(r, 32'h1);
    wb(1'b1, 12'h100, 32'hFF, 4'hF, r);
    wb(1'b0, 12'h100, 32'h0, 4'hF, r);
    chk(r, 32'h0);
    pg = 1'b1;
    // Wrap and page corners first
    op(4'h6, 8'hF0, 8'h00, 8'h20, 8'h00, 1'b1, 1'b0);
    op(4'h3, 8'h35, 8'h01, 8'h00, 8'h00, 1'b1, 1'b1);
    // Status word shows the last address and an idle sequencer
    wb(1'b0, 12'h3E0, 32'h0, 4'hF, r);
    chk(r, 32'h00000135);
    op(4'h8, 8'hFF, 8'hFF, 8'h00, 8'h02, 1'b0, 1'b0);
    op(4'hB, 8'hFF, 8'h00, 8'h00, 8'h10, 1'b1, 1'b0);
    repeat (150)
    begin
      if ($urandom_range(15) == 0)
      begin
        pg = 1'($urandom_range(1));
        wb(1'b1, 12'h384, {31'h0, pg}, 4'h1, r);
      end
      op(4'($urandom_range(15)), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
        1'($urandom_range(1)), 1'($urandom_range(1)));
    end
    close_out();
  end
endmodule // tb_oag_core
`default_nettype wire
